// ==== synth_latch_pkg.sv ====
// constants for the synthesizer latch control block
// assumes a 24-bit serial word, control bits in the two lowest positions
//
// Function
// - host shifts 24 bits msb first; strobe rising edge copies word
// - two lowest bits pick reference, feedback, function or init latch
// - ref word: 15..2 divide, 17..16 backlash, 19..18 test, 20 precision
// - feedback word: bit 21 gain, bits 20..8 main divide, 7..2 swallow
// - control bits 1,0 store the function latch fields
// - counter clear bit 2 holds reference and feedback counters reset
// - clearing counter clear releases both counters together for alignment
// - chip enable low powers the device down at once
// - request bit set with sync select clear: power down immediately
// - request bit with sync select set: power down at next pump event
// - power down loads counters, floats pump, clears lock; latching goes on
// - monitor pin follows the three select bits 6..4
// - bit 9 allows fastlock; bit 10 picks manual or timed exit
// - manual fastlock uses current two while gain bit is one
// - timed fastlock: gain starts timer, expiry clears gain bit
// - timeout counter runs only with timed variant selected
// - current one from bits 17..15, current two from bits 20..18
// - tristate bit 8 floats the pump output while set
// - init write loads function fields and pulses counter reset
// - init write with sync power down and enable high triggers it
// - first feedback write after init pulses counter reset again
// - lock after 3 or 5 good detector cycles; drops on large error
package synth_latch_pkg;
   localparam int WORD_W = 24;
   // ------------------------------------------------------------
   // latch selection
   // ------------------------------------------------------------
   localparam logic [1:0] SEL_REF = 2'h0;
   localparam logic [1:0] SEL_FB = 2'h1;
   localparam logic [1:0] SEL_FUNC = 2'h2;
   localparam logic [1:0] SEL_INIT = 2'h3;
   // ------------------------------------------------------------
   // reference divider latch fields
   // ------------------------------------------------------------
   localparam int REF_DIV_LSB = 2;
   localparam int REF_DIV_W = 14;
   localparam int BACKLASH_LSB = 16;
   localparam int TEST_LSB = 18;
   localparam int LOCK_PREC_BIT = 20;
   // ------------------------------------------------------------
   // feedback divider latch fields
   // ------------------------------------------------------------
   localparam int SWALLOW_LSB = 2;
   localparam int SWALLOW_W = 6;
   localparam int MAIN_DIV_LSB = 8;
   localparam int MAIN_DIV_W = 13;
   localparam int GAIN_BIT = 21;
   // ------------------------------------------------------------
   // function / init latch fields
   // ------------------------------------------------------------
   localparam int CLEAR_BIT = 2;
   localparam int PD_REQ_BIT = 3;
   localparam int MON_LSB = 4;
   localparam int POLARITY_BIT = 7;
   localparam int TRISTATE_BIT = 8;
   localparam int FAST_ALLOW_BIT = 9;
   localparam int FAST_VARIANT_BIT = 10;
   localparam int TIMEOUT_LSB = 11;
   localparam int CUR_ONE_LSB = 15;
   localparam int CUR_TWO_LSB = 18;
   localparam int PD_SYNC_BIT = 21;
   localparam int PRESCALER_LSB = 22;
   // ------------------------------------------------------------
   // reset values and timing counts
   // ------------------------------------------------------------
   localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
   localparam int LOCK_COUNT_NORMAL = 3;
   localparam int LOCK_COUNT_PRECISE = 5;
   localparam int TIMEOUT_STEP = 4;
   localparam int TIMEOUT_BASE = 3;
   // ------------------------------------------------------------
   // monitor pin selections
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MON_LOW, MON_LOCK, MON_PUMP_EVENT, MON_FASTLOCK,
      MON_POWERDOWN, MON_HOLD, MON_TRISTATE, MON_HIGH
   } monitor_sel_e;
endpackage : synth_latch_pkg

// ==== serial_word_if.sv ====
// carries the assembled serial word from the link domain to the core
// assumes the word is stable whenever the latch strobe is high
`timescale 1ns/1ps
interface serial_word_if;
   logic [23:0] word;
   modport shifter (output word);
   modport core (input word);
endinterface : serial_word_if

// ==== serial_shifter.sv ====
// 24-bit input shift register clocked by the host serial clock
// assumes the serial clock stands still while the latch strobe is high
`timescale 1ns/1ps
module serial_shifter (
   // link
   input wire logic i_sclk,
   input wire logic i_nrst,
   input wire logic i_sdata,
   // word to core
   serial_word_if.shifter sw
);
   logic [23:0] shift_q;

   // msb first: each edge moves older bits up
   always_ff @(posedge i_sclk or negedge i_nrst) begin
      if (!i_nrst) begin
         shift_q <= 24'h000000;
      end else begin
         shift_q <= {shift_q[22:0], i_sdata};
      end
   end

   assign sw.word = shift_q;
endmodule : serial_shifter

// ==== synth_latch_control.sv ====
// control logic behind the synthesizer programming latches
// assumes a host on a three-wire link, analog pump and detector outside
`timescale 1ns/1ps
module synth_latch_control
   import synth_latch_pkg::*;
#(
   parameter int LOCK_NORMAL = LOCK_COUNT_NORMAL,
   parameter int LOCK_PRECISE = LOCK_COUNT_PRECISE
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // serial link
   input wire logic i_sclk,
   input wire logic i_sdata,
   input wire logic i_latch_strobe,
   input wire logic i_chip_enable,
   // analog side events
   input wire logic i_pump_event,
   input wire logic i_det_cycle,
   input wire logic i_phase_small,
   input wire logic i_phase_large,
   // divider settings
   output logic [13:0] o_ref_divide,
   output logic [12:0] o_main_divide,
   output logic [5:0] o_swallow_count,
   output logic [1:0] o_antibacklash_width,
   output logic [1:0] o_test_mode,
   output logic [1:0] o_prescaler_sel,
   // pump and detector control
   output logic [2:0] o_pump_current,
   output logic o_pump_tristate,
   output logic o_detector_polarity,
   output logic o_counter_hold,
   // status
   output logic o_powered_down,
   output logic o_fastlock_active,
   output logic o_lock_detect,
   output logic o_monitor_output_pin
);
   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (LOCK_NORMAL < 1 || LOCK_PRECISE < LOCK_NORMAL ||
       LOCK_PRECISE > 7) begin : g_bad_lock
      $error("lock counts out of range");
   end

   typedef enum logic [1:0] {PWR_ON, PWR_PENDING, PWR_DOWN} pwr_e;

   function automatic logic [7:0] timeout_cycles(input logic [3:0] tc);
      timeout_cycles = 8'(TIMEOUT_STEP * int'(tc) + TIMEOUT_BASE);
   endfunction : timeout_cycles

   // ------------------------------------------------------------
   // link domain shifter
   // ------------------------------------------------------------
   serial_word_if sw ();

   serial_shifter u_shifter (
      .i_sclk(i_sclk),
      .i_nrst(i_nrst),
      .i_sdata(i_sdata),
      .sw(sw)
   );

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [4:0] meta_q;
   logic [4:0] sync_q;
   logic [4:0] pins;
   logic strobe_prev_q;
   logic pump_prev_q;
   logic det_prev_q;

   assign pins = {i_phase_large, i_phase_small, i_det_cycle,
                  i_pump_event, i_latch_strobe};

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_q <= 5'h00;
         sync_q <= 5'h00;
      end else begin
         meta_q <= pins;
         sync_q <= meta_q;
      end
   end

   // chip enable resets to low so the part starts powered down
   logic ce_meta_q;
   logic ce_q;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ce_meta_q <= 1'b0;
         ce_q <= 1'b0;
      end else begin
         ce_meta_q <= i_chip_enable;
         ce_q <= ce_meta_q;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         strobe_prev_q <= 1'b0;
         pump_prev_q <= 1'b0;
         det_prev_q <= 1'b0;
      end else begin
         strobe_prev_q <= sync_q[0];
         pump_prev_q <= sync_q[1];
         det_prev_q <= sync_q[2];
      end
   end

   logic strobe_rise;
   logic pump_rise;
   logic det_rise;
   logic phase_small;
   logic phase_large;

   assign strobe_rise = sync_q[0] & ~strobe_prev_q;
   assign pump_rise = sync_q[1] & ~pump_prev_q;
   assign det_rise = sync_q[2] & ~det_prev_q;
   assign phase_small = sync_q[3];
   assign phase_large = sync_q[4];

   // ------------------------------------------------------------
   // latch writes
   // ------------------------------------------------------------
   // word is stable two mclk edges after the strobe rises, since the
   // serial clock is quiet by then; no further crossing is needed
   logic [23:0] word;
   logic wr_ref;
   logic wr_fb;
   logic wr_func;
   logic wr_init;

   assign word = sw.word;
   assign wr_ref = strobe_rise && word[1:0] == SEL_REF;
   assign wr_fb = strobe_rise && word[1:0] == SEL_FB;
   assign wr_func = strobe_rise && word[1:0] == SEL_FUNC;
   assign wr_init = strobe_rise && word[1:0] == SEL_INIT;

   logic [13:0] ref_div_q;
   logic [1:0] backlash_q;
   logic [1:0] test_q;
   logic lock_prec_q;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ref_div_q <= 14'h0000;
         backlash_q <= 2'h0;
         test_q <= 2'h0;
         lock_prec_q <= 1'b0;
      end else if (wr_ref) begin
         ref_div_q <= word[REF_DIV_LSB +: REF_DIV_W];
         backlash_q <= word[BACKLASH_LSB +: 2];
         test_q <= word[TEST_LSB +: 2];
         lock_prec_q <= word[LOCK_PREC_BIT];
      end
   end

   logic [12:0] main_div_q;
   logic [5:0] swallow_q;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         main_div_q <= 13'h0000;
         swallow_q <= 6'h00;
      end else if (wr_fb) begin
         main_div_q <= word[MAIN_DIV_LSB +: MAIN_DIV_W];
         swallow_q <= word[SWALLOW_LSB +: SWALLOW_W];
      end
   end

   logic [23:0] func_q;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         func_q <= LATCH_RESET;
      end else if (wr_func || wr_init) begin
         func_q <= word;
      end
   end

   logic clear_bit;
   logic pd_req;
   logic pd_sync;
   logic fast_allow;
   logic fast_timed;
   logic [3:0] tc_sel;

   assign clear_bit = func_q[CLEAR_BIT];
   assign pd_req = func_q[PD_REQ_BIT];
   assign pd_sync = func_q[PD_SYNC_BIT];
   assign fast_allow = func_q[FAST_ALLOW_BIT];
   assign fast_timed = func_q[FAST_VARIANT_BIT];
   assign tc_sel = func_q[TIMEOUT_LSB +: 4];

   // ------------------------------------------------------------
   // internal reset pulse
   // ------------------------------------------------------------
   logic arm_q;
   logic pulse_q;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         arm_q <= 1'b0;
      end else if (wr_init) begin
         arm_q <= 1'b1;
      end else if (wr_fb) begin
         arm_q <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= wr_init || (wr_fb && arm_q);
      end
   end

   // ------------------------------------------------------------
   // power down
   // ------------------------------------------------------------
   pwr_e pwr_q;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         pwr_q <= PWR_DOWN;
      end else if (!ce_q) begin
         pwr_q <= PWR_DOWN;
      end else if (!pd_req) begin
         pwr_q <= PWR_ON;
      end else if (!pd_sync) begin
         pwr_q <= PWR_DOWN;
      end else begin
         unique case (pwr_q)
            PWR_ON, PWR_PENDING: begin
               // init pulse stands in for a pump event; it falls in the
               // cycle the request lands, so the on state must see it too
               if (pump_rise || pulse_q) begin
                  pwr_q <= PWR_DOWN;
               end else begin
                  pwr_q <= PWR_PENDING;
               end
            end
            PWR_DOWN: begin
               pwr_q <= PWR_DOWN;
            end
         endcase
      end
   end

   logic down;

   assign down = pwr_q == PWR_DOWN;

   // ------------------------------------------------------------
   // fastlock gain bit and timeout
   // ------------------------------------------------------------
   logic gain_q;
   logic [7:0] tmo_q;
   logic expire;

   assign expire = fast_allow && fast_timed && gain_q && det_rise &&
                   tmo_q == timeout_cycles(tc_sel) - 8'h01;

   // a feedback latch write in the expiry cycle wins over the auto clear
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         gain_q <= 1'b0;
      end else if (wr_fb) begin
         gain_q <= word[GAIN_BIT];
      end else if (expire) begin
         gain_q <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         tmo_q <= 8'h00;
      end else if (down || pulse_q || wr_fb || !gain_q) begin
         tmo_q <= 8'h00;
      end else if (fast_allow && fast_timed && det_rise) begin
         tmo_q <= expire ? 8'h00 : tmo_q + 8'h01;
      end
   end

   logic fast_on;

   assign fast_on = fast_allow && gain_q;

   // ------------------------------------------------------------
   // digital lock detect
   // ------------------------------------------------------------
   logic [2:0] good_q;
   logic lock_q;
   logic [2:0] need;

   assign need = lock_prec_q ? 3'(LOCK_PRECISE) : 3'(LOCK_NORMAL);

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         good_q <= 3'h0;
         lock_q <= 1'b0;
      end else if (down) begin
         good_q <= 3'h0;
         lock_q <= 1'b0;
      end else if (det_rise) begin
         if (phase_large) begin
            good_q <= 3'h0;
            lock_q <= 1'b0;
         end else if (phase_small) begin
            if (good_q + 3'h1 >= need) begin
               lock_q <= 1'b1;
            end
            if (good_q != need) begin
               good_q <= good_q + 3'h1;
            end
         end else begin
            good_q <= 3'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   logic hold;

   // clear bit holds, released counters restart together
   assign hold = clear_bit || pulse_q || down;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_counter_hold <= 1'b1;
         o_pump_tristate <= 1'b1;
         o_powered_down <= 1'b1;
      end else begin
         o_counter_hold <= hold;
         o_pump_tristate <= func_q[TRISTATE_BIT] || hold;
         o_powered_down <= down;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pump_current <= 3'h0;
         o_fastlock_active <= 1'b0;
      end else begin
         o_pump_current <= fast_on ? func_q[CUR_TWO_LSB +: 3]
                                   : func_q[CUR_ONE_LSB +: 3];
         o_fastlock_active <= fast_on;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ref_divide <= 14'h0000;
         o_main_divide <= 13'h0000;
         o_swallow_count <= 6'h00;
         o_antibacklash_width <= 2'h0;
         o_test_mode <= 2'h0;
         o_prescaler_sel <= 2'h0;
         o_detector_polarity <= 1'b0;
      end else begin
         o_ref_divide <= ref_div_q;
         o_main_divide <= main_div_q;
         o_swallow_count <= swallow_q;
         o_antibacklash_width <= backlash_q;
         o_test_mode <= test_q;
         o_prescaler_sel <= func_q[PRESCALER_LSB +: 2];
         o_detector_polarity <= func_q[POLARITY_BIT];
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_lock_detect <= 1'b0;
      end else begin
         o_lock_detect <= lock_q;
      end
   end

   // ------------------------------------------------------------
   // monitor output
   // ------------------------------------------------------------
   monitor_sel_e mon_sel;
   logic mon_d;

   assign mon_sel = monitor_sel_e'(func_q[MON_LSB +: 3]);

   always_comb begin
      unique case (mon_sel)
         MON_LOW: mon_d = 1'b0;
         MON_LOCK: mon_d = lock_q;
         MON_PUMP_EVENT: mon_d = sync_q[1];
         MON_FASTLOCK: mon_d = fast_on;
         MON_POWERDOWN: mon_d = down;
         MON_HOLD: mon_d = hold;
         MON_TRISTATE: mon_d = func_q[TRISTATE_BIT] || hold;
         MON_HIGH: mon_d = 1'b1;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_monitor_output_pin <= 1'b0;
      end else begin
         o_monitor_output_pin <= mon_d;
      end
   end
endmodule : synth_latch_control

// ==== synth_latch_properties.sv ====
// port checker for the synthesizer latch control block
// assumes it is bound to synth_latch_control, all in the i_mclk domain
`timescale 1ns/1ps
module synth_latch_checker (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // inputs watched
   input wire logic i_latch_strobe,
   input wire logic i_chip_enable,
   input wire logic i_pump_event,
   input wire logic i_det_cycle,
   input wire logic i_phase_large,
   // outputs watched
   input wire logic [13:0] o_ref_divide,
   input wire logic [12:0] o_main_divide,
   input wire logic [5:0] o_swallow_count,
   input wire logic [2:0] o_pump_current,
   input wire logic o_pump_tristate,
   input wire logic o_counter_hold,
   input wire logic o_powered_down,
   input wire logic o_fastlock_active,
   input wire logic o_lock_detect
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   ce_down_a: assert property (
      $fell(i_chip_enable) |-> ##[1:5] o_powered_down)
      else $error("no power down after chip enable low");
   pd_exit_a: assert property (
      $fell(o_powered_down) |-> $past(i_chip_enable, 2))
      else $error("power up while chip enable low");
   pd_effects_a: assert property (
      o_powered_down [*3] |->
         o_pump_tristate && o_counter_hold && !o_lock_detect)
      else $error("power down did not float pump or hold counters");
   lock_drop_a: assert property (
      $rose(i_det_cycle) && i_phase_large |-> ##[1:6] !o_lock_detect)
      else $error("lock kept after large phase error");
   lock_rise_a: assert property (
      (!i_det_cycle) [*8] |-> !$rose(o_lock_detect))
      else $error("lock rose without detector cycles");
   fast_quiet_a: assert property (
      (!i_latch_strobe && !i_det_cycle && !i_pump_event
         && i_chip_enable) [*8] |->
         $stable(o_fastlock_active) && $stable(o_pump_current))
      else $error("fastlock changed with no cause");
   hold_quiet_a: assert property (
      (!i_latch_strobe && !i_pump_event && i_chip_enable) [*8] |->
         $stable(o_counter_hold))
      else $error("counter hold changed with no cause");
   div_quiet_a: assert property (
      (!i_latch_strobe) [*6] |-> $stable(o_ref_divide)
         && $stable(o_main_divide) && $stable(o_swallow_count))
      else $error("divider changed without a strobe");
endmodule : synth_latch_checker

bind synth_latch_control synth_latch_checker u_chk (
   .i_mclk, .i_nrst, .i_latch_strobe, .i_chip_enable, .i_pump_event,
   .i_det_cycle, .i_phase_large, .o_ref_divide, .o_main_divide,
   .o_swallow_count, .o_pump_current, .o_pump_tristate, .o_counter_hold,
   .o_powered_down, .o_fastlock_active, .o_lock_detect
);

// ==== synth_host_model.sv ====
// host model driving the three-wire serial link
// assumes the caller starts a word on an i_mclk edge
`timescale 1ns/1ps
module synth_host_model (
   // strobe timing
   input wire logic i_mclk,
   // link pins
   output logic o_sclk,
   output logic o_sdata,
   output logic o_latch_strobe
);
   initial begin
      o_sclk = 1'b0;
      o_sdata = 1'b0;
      o_latch_strobe = 1'b0;
   end

   // 80 ns link period, clock parked low outside words
   task automatic send(input logic [23:0] w);
      #13;
      for (int i = 23; i >= 0; i--) begin
         o_sdata = w[i];
         #40 o_sclk = 1'b1;
         #40 o_sclk = 1'b0;
      end
      // released line must not keep the last bit
      o_sdata = ~w[0];
      @(posedge i_mclk);
      o_latch_strobe <= 1'b1;
      repeat (5) @(posedge i_mclk);
      o_latch_strobe <= 1'b0;
      repeat (5) @(posedge i_mclk);
   endtask : send
endmodule : synth_host_model

// ==== synth_latch_control_tb_top.sv ====
// self-checking bench for the synthesizer latch control block
// assumes the host model owns the link pins, bench drives the rest
`timescale 1ns/1ps
module synth_latch_control_tb_top
   import synth_latch_pkg::*;
;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_chip_enable = 1'b1;
   logic i_pump_event = 1'b0;
   logic i_det_cycle = 1'b0;
   logic i_phase_small = 1'b0;
   logic i_phase_large = 1'b0;
   logic i_sclk, i_sdata, i_latch_strobe;
   logic [13:0] o_ref_divide;
   logic [12:0] o_main_divide;
   logic [5:0] o_swallow_count;
   logic [1:0] o_antibacklash_width, o_test_mode, o_prescaler_sel;
   logic [2:0] o_pump_current;
   logic o_pump_tristate, o_detector_polarity, o_counter_hold;
   logic o_powered_down, o_fastlock_active, o_lock_detect;
   logic o_monitor_output_pin;
   int checks = 0;
   int bad_count = 0;
   int holds = 0;

   always #20 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      if (o_counter_hold === 1'b1) begin
         holds++;
      end
   end

   synth_host_model host (
      .i_mclk, .o_sclk(i_sclk), .o_sdata(i_sdata),
      .o_latch_strobe(i_latch_strobe)
   );
   synth_latch_control dut (
      .i_mclk, .i_nrst, .i_sclk, .i_sdata, .i_latch_strobe,
      .i_chip_enable, .i_pump_event, .i_det_cycle, .i_phase_small,
      .i_phase_large, .o_ref_divide, .o_main_divide, .o_swallow_count,
      .o_antibacklash_width, .o_test_mode, .o_prescaler_sel,
      .o_pump_current, .o_pump_tristate, .o_detector_polarity,
      .o_counter_hold, .o_powered_down, .o_fastlock_active,
      .o_lock_detect, .o_monitor_output_pin
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // f is {variant, allow, tristate, polarity, clear}, pd is {sync, req}
   function automatic logic [23:0] fw(input logic [2:0] c2, c1,
      input logic [3:0] tc, input logic [4:0] f, input logic [2:0] m,
      input logic [1:0] pd, input logic [1:0] sel);
      return {2'h1, pd[1], c2, c1, tc, f[4:1], m, pd[0], f[0], sel};
   endfunction : fw
   function automatic logic [23:0] fb(input logic g);
      return {2'h3, g, 13'h1b35, 6'h2d, SEL_FB};
   endfunction : fb
   function automatic logic [23:0] rw(input logic p, input logic [13:0] d);
      return {1'b1, 2'h0, p, 2'h1, 2'h2, d, SEL_REF};
   endfunction : rw
   task automatic func(input logic [3:0] tc, input logic [4:0] f,
      input logic [1:0] pd, input logic [1:0] sel);
      host.send(fw(3'h5, 3'h2, tc, f, 3'h0, pd, sel));
   endtask : func
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : cyc
   task automatic det(input logic s, input logic l);
      i_phase_small <= s;
      i_phase_large <= l;
      cyc(1);
      i_det_cycle <= 1'b1;
      cyc(2);
      i_det_cycle <= 1'b0;
      cyc(4);
   endtask : det

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_latch;
      host.send(rw(1'b0, 14'h3a5c));
      chk(24'(o_ref_divide), 24'h3a5c);
      chk(24'(o_antibacklash_width), 24'h2);
      chk(24'(o_test_mode), 24'h1);
      host.send(fb(1'b0));
      chk(24'(o_main_divide), 24'h1b35);
      chk(24'(o_swallow_count), 24'h2d);
      chk(24'(o_ref_divide), 24'h3a5c);
      for (int m = 0; m < 8; m++) begin
         host.send(fw(3'h5, 3'h2, 4'h0, {3'b001, m[0], 1'b0}, m[2:0],
            2'h0, SEL_FUNC));
         chk(24'(o_monitor_output_pin), 24'(m >= 6));
         chk(24'(o_detector_polarity), 24'(m[0]));
      end
      chk(24'(o_pump_tristate), 24'h1);
      chk(24'(o_pump_current), 24'h2);
      chk(24'(o_prescaler_sel), 24'h1);
      $display("latch write test done");
   endtask : t_latch

   task automatic t_pd;
      func(4'h0, 5'h01, 2'h0, SEL_FUNC);
      chk(24'(o_counter_hold), 24'h1);
      chk(24'(o_pump_tristate), 24'h1);
      func(4'h0, 5'h00, 2'h0, SEL_FUNC);
      chk(24'(o_counter_hold), 24'h0);
      chk(24'(o_pump_tristate), 24'h0);
      i_chip_enable <= 1'b0;
      cyc(5);
      chk(24'(o_powered_down), 24'h1);
      host.send(rw(1'b0, 14'h0155));
      chk(24'(o_ref_divide), 24'h0155);
      i_chip_enable <= 1'b1;
      cyc(6);
      chk(24'(o_powered_down), 24'h0);
      func(4'h0, 5'h00, 2'h1, SEL_FUNC);
      chk(24'(o_powered_down), 24'h1);
      func(4'h0, 5'h00, 2'h0, SEL_FUNC);
      func(4'h0, 5'h00, 2'h3, SEL_FUNC);
      chk(24'(o_powered_down), 24'h0);
      i_pump_event <= 1'b1;
      cyc(2);
      i_pump_event <= 1'b0;
      cyc(4);
      chk(24'(o_powered_down), 24'h1);
      func(4'h0, 5'h00, 2'h0, SEL_FUNC);
      chk(24'(o_powered_down), 24'h0);
      $display("power down test done");
   endtask : t_pd

   task automatic t_fast;
      host.send(fb(1'b1));
      chk(24'(o_fastlock_active), 24'h0);
      func(4'h0, 5'h08, 2'h0, SEL_FUNC);
      chk(24'(o_fastlock_active), 24'h1);
      chk(24'(o_pump_current), 24'h5);
      repeat (8) det(1'b0, 1'b0);
      chk(24'(o_fastlock_active), 24'h1);
      host.send(fb(1'b0));
      chk(24'(o_pump_current), 24'h2);
      // timeout code 1 lasts seven detector cycles
      func(4'h1, 5'h18, 2'h0, SEL_FUNC);
      host.send(fb(1'b1));
      repeat (6) det(1'b0, 1'b0);
      chk(24'(o_fastlock_active), 24'h1);
      det(1'b0, 1'b0);
      cyc(2);
      chk(24'(o_fastlock_active), 24'h0);
      chk(24'(o_pump_current), 24'h2);
      $display("fastlock test done");
   endtask : t_fast

   task automatic t_lock;
      for (int p = 0; p < 2; p++) begin
         host.send(rw(p[0], 14'h0155));
         repeat (2 + 2 * p) det(1'b1, 1'b0);
         chk(24'(o_lock_detect), 24'h0);
         det(1'b1, 1'b0);
         chk(24'(o_lock_detect), 24'h1);
         det(1'b0, 1'b0);
         det(1'b0, 1'b1);
         chk(24'(o_lock_detect), 24'h0);
      end
      $display("lock detect test done");
   endtask : t_lock

   task automatic t_init;
      int h;
      h = holds;
      host.send(fw(3'h5, 3'h2, 4'h0, 5'h00, 3'h7, 2'h0, SEL_INIT));
      chk(24'(holds - h), 24'h1);
      chk(24'(o_monitor_output_pin), 24'h1);
      host.send(fb(1'b0));
      chk(24'(holds - h), 24'h2);
      host.send(fb(1'b0));
      chk(24'(holds - h), 24'h2);
      func(4'h0, 5'h00, 2'h3, SEL_INIT);
      chk(24'(o_powered_down), 24'h1);
      func(4'h0, 5'h00, 2'h0, SEL_FUNC);
      chk(24'(o_powered_down), 24'h0);
      $display("init latch test done");
   endtask : t_init

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   initial begin
      cyc(20);
      i_nrst <= 1'b1;
      cyc(6);
      t_latch();
      t_pd();
      t_fast();
      t_lock();
      t_init();
      summarize();
   end

   // run needs roughly 80 us
   initial begin
      #400000;
      bad_count++;
      summarize();
   end
endmodule : synth_latch_control_tb_top
